/* File: shared/mmcr_pkg.sv */
// constants for the modem mode control register pair
package mmcr_pkg;

  // ---------------------------------------------------------------
  // register addresses on the four-line host bus
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE_A = 4'h9;
  localparam logic [3:0] ADDR_MODE_B = 4'ha;

  // ---------------------------------------------------------------
  // reset values and writable-bit masks
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_A_RESET = 8'h00;
  localparam logic [7:0] MODE_B_RESET = 8'h00;
  localparam logic [7:0] MODE_A_MASK = 8'h7f;
  localparam logic [7:0] MODE_B_MASK = 8'h5f;

  // ---------------------------------------------------------------
  // mode register a fields
  // ---------------------------------------------------------------
  localparam int A_TX_CLOCK_SOURCE_SELECT = 6;
  localparam int A_RX_RANGE_EXTENDER = 5;
  localparam int A_SYNC_SELECT = 4;
  localparam int A_WORD_LENGTH_SEL_HI = 3;
  localparam int A_WORD_LENGTH_SEL_LO = 2;
  localparam int A_ANSWER_SELECT = 1;
  localparam int A_RX_DATA_CLAMP_HIGH = 0;

  // ---------------------------------------------------------------
  // mode register b fields
  // ---------------------------------------------------------------
  localparam int B_POWER_DOWN = 6;
  localparam int B_CALL_PROGRESS_MONITOR = 4;
  localparam int B_ANALOG_LOOPBACK = 3;
  localparam int B_TX_LEVEL_BIT2 = 2;
  localparam int B_TX_LEVEL_BIT0 = 0;

  // ---------------------------------------------------------------
  // derived settings
  // ---------------------------------------------------------------
  localparam logic [3:0] CHAR_LENGTH_BASE = 4'h8;
  localparam logic [2:0] PATTERN_DIGITAL_LOOPBACK = 3'h4;
  localparam int CHARS_PER_ADJUST = 4;

  localparam logic [1:0] CLK_SRC_INTERNAL = 2'h0;
  localparam logic [1:0] CLK_SRC_TERMINAL = 2'h1;
  localparam logic [1:0] CLK_SRC_SLAVE = 2'h2;

  localparam logic [1:0] RX_PATH_NORMAL = 2'h0;
  localparam logic [1:0] RX_PATH_ANALOG_LOOP = 2'h1;
  localparam logic [1:0] RX_PATH_HIGH_BAND = 2'h2;
  localparam logic [1:0] RX_PATH_LOW_BAND_SCALED = 2'h3;

  // ---------------------------------------------------------------
  // host pin synchroniser: {addr, data, cs_n, wr_n}
  // ---------------------------------------------------------------
  localparam int BUS_SYNC_WIDTH = 14;
  localparam logic [13:0] BUS_IDLE = 14'h0003;

endpackage

/* File: shared/mmcr_conv_if.sv */
// link between the mode block and one converter credit keeper
`timescale 1ns/1ps
interface mmcr_conv_if;
  logic enable;
  logic char_done;
  logic adjust_req;
  logic adjust_grant;

  modport budget
  (
    input enable,
    input char_done,
    input adjust_req,
    output adjust_grant
  );

  modport user
  (
    output enable,
    output char_done,
    output adjust_req,
    input adjust_grant
  );
endinterface

/* File: core/mmcr_stop_budget.sv */
// one stop-bit adjustment allowed per run of characters
`timescale 1ns/1ps
module mmcr_stop_budget #(
  parameter int CHARS = mmcr_pkg::CHARS_PER_ADJUST
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  mmcr_conv_if.budget conv
);

  localparam logic [2:0] FULL = 3'(CHARS);

  logic [2:0] credit;
  logic grant_now;

  // ---------------------------------------------------------------
  // credit count since the last adjustment
  // ---------------------------------------------------------------
  assign grant_now = conv.enable && conv.adjust_req && (credit >= FULL);

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      credit <= 3'h0;
    end
    else if (grant_now)
    begin
      credit <= conv.char_done ? 3'h1 : 3'h0;
    end
    else if (conv.char_done && (credit < FULL))
    begin
      credit <= credit + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      conv.adjust_grant <= 1'b0;
    end
    else
    begin
      conv.adjust_grant <= grant_now;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  grant_needs_credit_a: assert property (
    conv.adjust_grant |-> $past(credit) == FULL && $past(conv.enable))
    else $error("stop adjust granted without full credit");

  grant_spacing_a: assert property (
    conv.adjust_grant |=> !conv.adjust_grant)
    else $error("two stop adjustments back to back");

  grant_on_request_a: assert property (
    conv.enable && conv.adjust_req && credit == FULL |=> conv.adjust_grant)
    else $error("stop adjust refused with full credit");

endmodule

/* File: core/mmcr_mode_control.sv */
// mode control register pair of the low-speed modem and its derived controls
`timescale 1ns/1ps
module mmcr_mode_control (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] host_addr_in,
  input wire logic [7:0] host_data_in,
  input wire logic host_cs_n_in,
  input wire logic host_wr_n_in,
  input wire logic [2:0] transmit_pattern_select_in,
  input wire logic rx_demod_data_in,
  input wire logic rx_descrambled_data_in,
  input wire logic dte_tx_data_in,
  input wire logic rx_char_done_in,
  input wire logic rx_stop_insert_req_in,
  input wire logic tx_char_done_in,
  input wire logic tx_stop_adjust_req_in,
  output logic [7:0] mode_control_a_out,
  output logic [7:0] mode_control_b_out,
  output logic [1:0] tx_clock_source_select_out,
  output logic sync_mode_out,
  output logic [3:0] char_length_out,
  output logic answer_mode_out,
  output logic rxd_out,
  output logic scrambler_data_out,
  output logic digital_loopback_out,
  output logic power_down_out,
  output logic analog_loopback_out,
  output logic [1:0] rx_path_select_out,
  output logic [2:0] tx_level_code_out,
  output logic [3:0] tx_atten_db_out,
  output logic rx_range_extender_out,
  output logic rx_stop_insert_grant_out,
  output logic tx_stop_adjust_grant_out
);

  localparam int SW = mmcr_pkg::BUS_SYNC_WIDTH;

  logic [SW-1:0] bus_meta;
  logic [SW-1:0] bus_sync;
  logic wr_n_prev;
  logic [3:0] addr_s;
  logic [7:0] data_s;
  logic cs_n_s;
  logic wr_n_s;
  logic write_taken;
  logic write_a;
  logic write_b;
  logic [7:0] mode_control_a;
  logic [7:0] mode_control_b;
  logic dig_loop;
  logic eff_sync;
  logic [1:0] next_clk_src;
  logic [1:0] next_rx_path;
  logic [3:0] next_char_length;

  // ---------------------------------------------------------------
  // host pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      bus_meta <= mmcr_pkg::BUS_IDLE;
      bus_sync <= mmcr_pkg::BUS_IDLE;
    end
    else
    begin
      bus_meta <= {host_addr_in, host_data_in, host_cs_n_in, host_wr_n_in};
      bus_sync <= bus_meta;
    end
  end

  assign {addr_s, data_s, cs_n_s, wr_n_s} = bus_sync;

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_n_prev <= 1'b1;
    end
    else
    begin
      wr_n_prev <= wr_n_s;
    end
  end

  // write taken on the trailing edge of the strobe while selected
  assign write_taken = wr_n_s && !wr_n_prev && !cs_n_s;
  assign write_a = write_taken && (addr_s == mmcr_pkg::ADDR_MODE_A);
  assign write_b = write_taken && (addr_s == mmcr_pkg::ADDR_MODE_B);

  // ---------------------------------------------------------------
  // mode registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mode_control_a <= mmcr_pkg::MODE_A_RESET;
    end
    else if (write_a)
    begin
      mode_control_a <= data_s & mmcr_pkg::MODE_A_MASK;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mode_control_b <= mmcr_pkg::MODE_B_RESET;
    end
    else if (write_b)
    begin
      mode_control_b <= data_s & mmcr_pkg::MODE_B_MASK;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mode_control_a_out <= mmcr_pkg::MODE_A_RESET;
      mode_control_b_out <= mmcr_pkg::MODE_B_RESET;
    end
    else
    begin
      mode_control_a_out <= mode_control_a;
      mode_control_b_out <= mode_control_b;
    end
  end

  // ---------------------------------------------------------------
  // derived operating mode
  // ---------------------------------------------------------------
  assign dig_loop = transmit_pattern_select_in == mmcr_pkg::PATTERN_DIGITAL_LOOPBACK;
  assign eff_sync = mode_control_a[mmcr_pkg::A_SYNC_SELECT] || dig_loop;

  always_comb
  begin
    if (dig_loop)
    begin
      next_clk_src = mmcr_pkg::CLK_SRC_SLAVE;
    end
    else if (mode_control_a[mmcr_pkg::A_TX_CLOCK_SOURCE_SELECT])
    begin
      next_clk_src = mmcr_pkg::CLK_SRC_TERMINAL;
    end
    else
    begin
      next_clk_src = mmcr_pkg::CLK_SRC_INTERNAL;
    end
  end

  // 10 -> 8, 11 -> 9, 00 -> 10, 01 -> 11
  assign next_char_length = mmcr_pkg::CHAR_LENGTH_BASE
    + {2'h0, !mode_control_a[mmcr_pkg::A_WORD_LENGTH_SEL_HI],
       mode_control_a[mmcr_pkg::A_WORD_LENGTH_SEL_LO]};

  always_comb
  begin
    if (mode_control_b[mmcr_pkg::B_CALL_PROGRESS_MONITOR])
    begin
      next_rx_path = mode_control_b[mmcr_pkg::B_ANALOG_LOOPBACK]
        ? mmcr_pkg::RX_PATH_LOW_BAND_SCALED : mmcr_pkg::RX_PATH_HIGH_BAND;
    end
    else if (mode_control_b[mmcr_pkg::B_ANALOG_LOOPBACK])
    begin
      next_rx_path = mmcr_pkg::RX_PATH_ANALOG_LOOP;
    end
    else
    begin
      next_rx_path = mmcr_pkg::RX_PATH_NORMAL;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      tx_clock_source_select_out <= mmcr_pkg::CLK_SRC_INTERNAL;
      sync_mode_out <= 1'b0;
      char_length_out <= 4'ha;
      answer_mode_out <= 1'b0;
      digital_loopback_out <= 1'b0;
      rx_range_extender_out <= 1'b0;
    end
    else
    begin
      tx_clock_source_select_out <= next_clk_src;
      sync_mode_out <= eff_sync;
      char_length_out <= next_char_length;
      answer_mode_out <= mode_control_a[mmcr_pkg::A_ANSWER_SELECT];
      digital_loopback_out <= dig_loop;
      rx_range_extender_out <= mode_control_a[mmcr_pkg::A_RX_RANGE_EXTENDER];
    end
  end

  // ---------------------------------------------------------------
  // data steering
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rxd_out <= 1'b1;
      scrambler_data_out <= 1'b1;
    end
    else
    begin
      rxd_out <= mode_control_a[mmcr_pkg::A_RX_DATA_CLAMP_HIGH] || rx_demod_data_in;
      scrambler_data_out <= dig_loop ? rx_descrambled_data_in : dte_tx_data_in;
    end
  end

  // ---------------------------------------------------------------
  // analog front end controls
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      power_down_out <= 1'b0;
      analog_loopback_out <= 1'b0;
      rx_path_select_out <= mmcr_pkg::RX_PATH_NORMAL;
      tx_level_code_out <= 3'h0;
      tx_atten_db_out <= 4'h0;
    end
    else
    begin
      power_down_out <= mode_control_b[mmcr_pkg::B_POWER_DOWN];
      analog_loopback_out <= mode_control_b[mmcr_pkg::B_ANALOG_LOOPBACK];
      rx_path_select_out <= next_rx_path;
      tx_level_code_out <= mode_control_b[mmcr_pkg::B_TX_LEVEL_BIT2:mmcr_pkg::B_TX_LEVEL_BIT0];
      tx_atten_db_out <= {mode_control_b[mmcr_pkg::B_TX_LEVEL_BIT2:mmcr_pkg::B_TX_LEVEL_BIT0],
                          1'b0};
    end
  end

  // ---------------------------------------------------------------
  // sync converter stop-bit credit
  // ---------------------------------------------------------------
  mmcr_conv_if rx_conv ();
  mmcr_conv_if tx_conv ();

  assign rx_conv.enable = mode_control_a[mmcr_pkg::A_RX_RANGE_EXTENDER];
  assign rx_conv.char_done = rx_char_done_in;
  assign rx_conv.adjust_req = rx_stop_insert_req_in;
  assign tx_conv.enable = 1'b1;
  assign tx_conv.char_done = tx_char_done_in;
  assign tx_conv.adjust_req = tx_stop_adjust_req_in;
  assign rx_stop_insert_grant_out = rx_conv.adjust_grant;
  assign tx_stop_adjust_grant_out = tx_conv.adjust_grant;

  mmcr_stop_budget #(
    .CHARS(mmcr_pkg::CHARS_PER_ADJUST)
  ) u_rx_budget (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .conv(rx_conv.budget)
  );

  mmcr_stop_budget #(
    .CHARS(mmcr_pkg::CHARS_PER_ADJUST)
  ) u_tx_budget (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .conv(tx_conv.budget)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence host_write_a_s;
    write_a ##1 1'b1;
  endsequence

  sequence host_write_b_s;
    write_b ##1 1'b1;
  endsequence

  write_a_store_a: assert property (
    write_a |=> mode_control_a == ($past(data_s) & mmcr_pkg::MODE_A_MASK))
    else $error("mode a write not stored");

  write_b_store_a: assert property (
    write_b |=> mode_control_b[7] == 1'b0 && mode_control_b[5] == 1'b0
      && mode_control_b[4:0] == $past(data_s[4:0]))
    else $error("mode b write wrong");

  no_write_hold_a: assert property (
    !write_a && !write_b |=> $stable(mode_control_a) && $stable(mode_control_b))
    else $error("mode register changed without write");

  clamp_rxd_a: assert property (
    mode_control_a[0] |=> rxd_out == 1'b1)
    else $error("rxd not clamped high");

  rxd_follow_a: assert property (
    !mode_control_a[0] |=> rxd_out == $past(rx_demod_data_in))
    else $error("rxd does not follow demodulator");

  loop_sync_a: assert property (
    dig_loop |=> sync_mode_out && tx_clock_source_select_out == mmcr_pkg::CLK_SRC_SLAVE)
    else $error("digital loop-back not synchronous slave");

  loop_data_a: assert property (
    dig_loop |=> scrambler_data_out == $past(rx_descrambled_data_in))
    else $error("loop-back data not returned");

  sync_select_a: assert property (
    !dig_loop |=> sync_mode_out == $past(mode_control_a[4]))
    else $error("sync mode not from register");

  clock_source_a: assert property (
    !dig_loop && mode_control_a[6] |=> tx_clock_source_select_out == mmcr_pkg::CLK_SRC_TERMINAL)
    else $error("terminal clock not selected");

  word_length_a: assert property (
    host_write_a_s |=> char_length_out == (($past(mode_control_a[3:2], 1) == 2'h2) ? 4'h8 :
      ($past(mode_control_a[3:2], 1) == 2'h3) ? 4'h9 :
      ($past(mode_control_a[3:2], 1) == 2'h0) ? 4'ha : 4'hb))
    else $error("character length wrong");

  answer_mode_a: assert property (
    host_write_a_s |=> answer_mode_out == $past(mode_control_a[1]))
    else $error("answer mode not applied");

  power_down_a: assert property (
    host_write_b_s |=> power_down_out == $past(data_s[6], 3))
    else $error("power down not applied");

  call_progress_a: assert property (
    mode_control_b[4] |=> rx_path_select_out == ($past(mode_control_b[3])
      ? mmcr_pkg::RX_PATH_LOW_BAND_SCALED : mmcr_pkg::RX_PATH_HIGH_BAND))
    else $error("call progress path wrong");

  analog_loop_a: assert property (
    !mode_control_b[4] && mode_control_b[3] |=> rx_path_select_out == mmcr_pkg::RX_PATH_ANALOG_LOOP)
    else $error("analog loop path wrong");

  tx_level_a: assert property (
    1'b1 |=> tx_atten_db_out == 4'($past(mode_control_b[2:0]) * 2))
    else $error("transmit level step wrong");

endmodule

/* File: sim/mmcr_host_model.sv */
// host processor model writing the mode control registers
`timescale 1ns/1ps
module mmcr_host_model (
  input wire logic clk_in,
  output logic [3:0] addr_out,
  output logic [7:0] data_out,
  output logic cs_n_out,
  output logic wr_n_out
);
  initial
  begin
    addr_out = 4'h0;
    data_out = 8'h00;
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
  end

  // strobe low four cycles, lines held four cycles past its rise
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
    @(posedge clk_in);
    addr_out <= addr;
    data_out <= data;
    cs_n_out <= 1'b0;
    wr_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    wr_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    // released lines do not keep the last value
    addr_out <= ~addr;
    data_out <= ~data;
    repeat (4) @(posedge clk_in);
  endtask
endmodule

/* File: sim/modem_mode_control_registers_tb_top.sv */
// self-checking bench for the mode control register pair
`timescale 1ns/1ps
module modem_mode_control_registers_tb_top;
  logic ref_clk;
  logic resetn;
  logic [3:0] h_addr;
  logic [7:0] h_data;
  logic h_cs_n;
  logic h_wr_n;
  logic [2:0] pat;
  logic demod, descr, dte, rx_cd, rx_req, tx_cd, tx_req;
  logic [7:0] mca, mcb;
  logic [1:0] clk_src, rxp;
  logic [3:0] clen, att;
  logic [2:0] lvl;
  logic sync, ans, rxd, scr, dlb, pwr_dn, ana_loop, rng, rx_gnt, tx_gnt;
  int num_errors = 0;
  int checks = 0;

  mmcr_host_model host (.clk_in(ref_clk), .addr_out(h_addr), .data_out(h_data),
    .cs_n_out(h_cs_n), .wr_n_out(h_wr_n));

  mmcr_mode_control dut (.ref_clk_in(ref_clk), .resetn_in(resetn), .host_addr_in(h_addr),
    .host_data_in(h_data), .host_cs_n_in(h_cs_n), .host_wr_n_in(h_wr_n),
    .transmit_pattern_select_in(pat), .rx_demod_data_in(demod),
    .rx_descrambled_data_in(descr), .dte_tx_data_in(dte), .rx_char_done_in(rx_cd),
    .rx_stop_insert_req_in(rx_req), .tx_char_done_in(tx_cd),
    .tx_stop_adjust_req_in(tx_req), .mode_control_a_out(mca), .mode_control_b_out(mcb),
    .tx_clock_source_select_out(clk_src), .sync_mode_out(sync), .char_length_out(clen),
    .answer_mode_out(ans), .rxd_out(rxd), .scrambler_data_out(scr),
    .digital_loopback_out(dlb), .power_down_out(pwr_dn), .analog_loopback_out(ana_loop),
    .rx_path_select_out(rxp), .tx_level_code_out(lvl), .tx_atten_db_out(att),
    .rx_range_extender_out(rng), .rx_stop_insert_grant_out(rx_gnt),
    .tx_stop_adjust_grant_out(tx_gnt));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic final_report;
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.write_reg(a, d);
    #1;
  endtask

  task automatic do_reset;
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1;
  endtask

  // n characters, one request, then count grants in a short window
  task automatic credit_try(input bit tx, input int n, input int e);
    int g;
    g = 0;
    repeat (n)
    begin
      @(posedge ref_clk);
      rx_cd <= !tx;
      tx_cd <= tx;
    end
    @(posedge ref_clk);
    rx_cd <= 1'b0;
    tx_cd <= 1'b0;
    rx_req <= !tx;
    tx_req <= tx;
    @(posedge ref_clk);
    rx_req <= 1'b0;
    tx_req <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      #1;
      if ((tx ? tx_gnt : rx_gnt) === 1'b1)
        g++;
      @(posedge ref_clk);
    end
    chk("stop grants", 8'(e), 8'(g));
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("mode a", 8'h00, mca);
    chk("mode b", 8'h00, mcb);
    chk("char length", 8'h0a, {4'h0, clen});
    chk("power down", 8'h00, {7'h0, pwr_dn});
    chk("rx path", 8'h00, {6'h0, rxp});
  endtask

  task automatic t_mode_a;
    wr(4'h9, 8'hff);
    chk("mode a", 8'h7f, mca);
    chk("clock source", 8'h01, {6'h0, clk_src});
    chk("range ext", 8'h01, {7'h0, rng});
    chk("sync", 8'h01, {7'h0, sync});
    chk("answer", 8'h01, {7'h0, ans});
    @(posedge ref_clk);
    demod <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("rxd clamped", 8'h01, {7'h0, rxd});
    wr(4'h9, 8'h00);
    chk("answer", 8'h00, {7'h0, ans});
    chk("sync", 8'h00, {7'h0, sync});
    chk("clock source", 8'h00, {6'h0, clk_src});
    chk("rxd free", 8'h00, {7'h0, rxd});
    @(posedge ref_clk);
    demod <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("rxd free", 8'h01, {7'h0, rxd});
  endtask

  task automatic t_word_len;
    logic [3:0] wl [4];
    wl = '{4'ha, 4'hb, 4'h8, 4'h9};
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h9, 8'(i << 2));
      chk("char length", {4'h0, wl[i]}, {4'h0, clen});
    end
  endtask

  task automatic t_mode_b;
    wr(4'ha, 8'hff);
    chk("mode b", 8'h5f, mcb);
    chk("power down", 8'h01, {7'h0, pwr_dn});
    chk("analog loop", 8'h01, {7'h0, ana_loop});
    chk("rx path", 8'h03, {6'h0, rxp});
    wr(4'ha, 8'h10);
    chk("rx path", 8'h02, {6'h0, rxp});
    chk("power down", 8'h00, {7'h0, pwr_dn});
    wr(4'ha, 8'h08);
    chk("rx path", 8'h01, {6'h0, rxp});
    for (int i = 0; i < 8; i++)
    begin
      wr(4'ha, 8'(i));
      chk("tx level", 8'(i), {5'h0, lvl});
      chk("tx atten", 8'(2 * i), {4'h0, att});
    end
  endtask

  task automatic t_unmapped;
    for (int a = 0; a < 16; a++)
    begin
      if (a != 9 && a != 10)
        wr(4'(a), 8'hff);
    end
    chk("mode a kept", 8'h0c, mca);
    chk("mode b kept", 8'h07, mcb);
  endtask

  task automatic t_loopback;
    @(posedge ref_clk);
    pat <= 3'h4;
    descr <= 1'b1;
    dte <= 1'b0;
    wr(4'h9, 8'h40);
    chk("clock source", 8'h02, {6'h0, clk_src});
    chk("sync", 8'h01, {7'h0, sync});
    chk("digital loop", 8'h01, {7'h0, dlb});
    chk("scrambler in", 8'h01, {7'h0, scr});
    @(posedge ref_clk);
    descr <= 1'b0;
    dte <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("scrambler in", 8'h00, {7'h0, scr});
    @(posedge ref_clk);
    pat <= 3'h0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("clock source", 8'h01, {6'h0, clk_src});
    chk("sync", 8'h00, {7'h0, sync});
    chk("scrambler in", 8'h01, {7'h0, scr});
  endtask

  task automatic t_credit;
    do_reset();
    wr(4'h9, 8'h20);
    credit_try(1'b0, 3, 0);
    credit_try(1'b0, 1, 1);
    credit_try(1'b0, 0, 0);
    credit_try(1'b1, 3, 0);
    credit_try(1'b1, 1, 1);
    credit_try(1'b1, 0, 0);
    wr(4'h9, 8'h00);
    credit_try(1'b0, 4, 0);
    credit_try(1'b1, 4, 1);
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog, main sequence
  // ---------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end

  initial
  begin
    resetn = 1'b0;
    pat = 3'h0;
    demod = 1'b1;
    descr = 1'b1;
    dte = 1'b1;
    rx_cd = 1'b0;
    rx_req = 1'b0;
    tx_cd = 1'b0;
    tx_req = 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_mode_a();
    t_word_len();
    t_mode_b();
    t_unmapped();
    t_loopback();
    t_credit();
    final_report();
  end
endmodule
